// ==== include/rcrt_pkg.sv ====
// shared constants and carrier types for the real-time coexistence signalling block
package rcrt_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_PS  = 25000;     // core_clk at 40 MHz
  localparam int GAP_LEAD_NS    = 1000000;   // envelope leads the air gap by 1 ms
  // longest-style figure, rounded down, exact here
  localparam int GAP_LEAD_CYC   = (GAP_LEAD_NS * 1000) / CLK_PERIOD_PS;
  localparam int MARK_WIDTH_NS  = 1000;      // frame marker pulse width
  // least time, rounded up
  localparam int MARK_WIDTH_CYC = (MARK_WIDTH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ****************************************
  // widths and reset values
  // ****************************************
  localparam int   STAMP_W     = 16;         // edge time stamp width
  localparam int   QUEUE_DEPTH = 8;          // pending envelope edges
  localparam int   QPTR_W      = 3;
  localparam int   MARK_CNT_W  = 8;
  localparam logic PIN_IDLE    = 1'b0;       // coexistence outputs at rest

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {RCRT_OFF, RCRT_ARMED, RCRT_ON} rcrt_mode_type;

  // timing from the layer-1 subsystem, same clock
  typedef struct packed {
    logic frame_tick;   // one-cycle pulse at each frame start
    logic ul_tx_plan;   // uplink plan, running one lead time ahead of the air
  } rcrt_l1_in_type;

  // state returned to the layer-1 subsystem
  typedef struct packed {
    logic ul_tx_air;       // uplink on air, plan delayed by the lead time
    logic peer_hipri;      // synchronised peer priority
    logic peer_collision;  // high priority peer while lte uplink is on air, coordination running
    logic queue_overflow;  // sticky: envelope edges came too densely
    logic rt_active;       // real-time coordination running
  } rcrt_l1_out_type;

endpackage : rcrt_pkg

// ==== hw/rcrt_gap_delay.sv ====
// lead-time delay line for the uplink plan, built from edge time stamps
`timescale 1ns/1ps
module rcrt_gap_delay #(
  parameter int LEAD_CYC = rcrt_pkg::GAP_LEAD_CYC
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_sync_b,
  // plan in, air out
  input  wire logic ul_tx_plan,
  output logic      plan_q,
  output logic      ul_tx_air,
  output logic      overflow
);
  import rcrt_pkg::*;

  localparam logic [STAMP_W-1:0] LEAD = STAMP_W'(LEAD_CYC);

  typedef struct packed {
    logic [STAMP_W-1:0]                  now;
    logic                                plan;
    logic                                air;
    logic [QUEUE_DEPTH-1:0][STAMP_W-1:0] stamp;
    logic [QPTR_W-1:0]                   wr;
    logic [QPTR_W-1:0]                   rd;
    logic [QPTR_W:0]                     fill;
    logic                                ovf;
  } rcrt_dly_type;

  rcrt_dly_type s_r;
  rcrt_dly_type s_nxt;
  logic         edge_seen;
  logic         due;
  logic         push;

  // ****************************************
  // next state
  // ****************************************
  // each plan edge that fits in the queue is stamped; it replays once its age equals the lead
  always_comb begin
    s_nxt     = s_r;
    s_nxt.now = s_r.now + 1'b1;
    s_nxt.plan = ul_tx_plan;
    edge_seen = ul_tx_plan != s_r.plan;
    due       = (s_r.fill != '0) && ((s_r.now - s_r.stamp[s_r.rd]) == LEAD);
    push      = edge_seen && !((s_r.fill == (QPTR_W+1)'(QUEUE_DEPTH)) && !due);
    if (due) begin
      s_nxt.air = ~s_r.air;
      s_nxt.rd  = s_r.rd + 1'b1;
    end
    if (edge_seen && !push) begin
      s_nxt.ovf = 1'b1;                  // edge lost, air view now inverted
    end
    if (push) begin
      s_nxt.stamp[s_r.wr] = s_r.now;
      s_nxt.wr            = s_r.wr + 1'b1;
    end
    s_nxt.fill = s_r.fill + (QPTR_W+1)'(push) - (QPTR_W+1)'(due);
  end

  // state register
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign plan_q    = s_r.plan;
  assign ul_tx_air = s_r.air;
  assign overflow  = s_r.ovf;

endmodule : rcrt_gap_delay

// ==== hw/rcrt_top.sv ====
// real-time coexistence signalling: frame marker, gap envelope, peer priority
// ****************************************
// How it works
// - three pins: two outputs, one priority input
// - frame marker pulses at each lte frame start
// - envelope edges lead air gap edges by 1ms
// - arbiter combines layer-1 state and peer priority
// - stays disabled until the coordinator enables it
// ****************************************
`timescale 1ns/1ps
module rcrt_top #(
  parameter int LEAD_CYC = rcrt_pkg::GAP_LEAD_CYC
) (
  // clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rst_b,
  // planning level coordinator
  input  wire logic                      rt_enable,
  // layer-1 subsystem
  input  wire rcrt_pkg::rcrt_l1_in_type  l1_in,
  output rcrt_pkg::rcrt_l1_out_type      l1_out,
  // coexistence pins
  output logic                           frame_marker_pin,
  output logic                           uplink_gap_envelope_pin,
  input  wire logic                      peer_priority_pin
);
  import rcrt_pkg::*;

  typedef struct packed {
    logic                  prio_meta;
    logic                  prio_sync;
    rcrt_mode_type         mode;
    logic [MARK_CNT_W-1:0] mark_cnt;
    logic                  marker;
    logic                  envelope;
    logic                  collision;
  } rcrt_state_type;

  localparam logic [MARK_CNT_W-1:0] MARK_LOAD = MARK_CNT_W'(MARK_WIDTH_CYC);

  logic [1:0]     rst_pipe_r;
  logic           rst_sync_b;
  rcrt_state_type s_r;
  rcrt_state_type s_nxt;
  logic           plan_q;
  logic           ul_tx_air;
  logic           overflow;
  logic           gap_raw;
  logic           start_mark;

  // ****************************************
  // reset release
  // ****************************************
  // asynchronous assert, two-flop synchronous release
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_pipe_r <= 2'h0;
    end else begin
      rst_pipe_r <= {rst_pipe_r[0], 1'b1};
    end
  end
  assign rst_sync_b = rst_pipe_r[1];

  // ****************************************
  // lead-time delay of the uplink plan
  // ****************************************
  rcrt_gap_delay #(
    .LEAD_CYC   (LEAD_CYC)
  ) u_gap_delay (
    .core_clk   (core_clk),
    .rst_sync_b (rst_sync_b),
    .ul_tx_plan (l1_in.ul_tx_plan),
    .plan_q     (plan_q),
    .ul_tx_air  (ul_tx_air),
    .overflow   (overflow)
  );

  // gap is the plan inverted: high when no uplink is planned
  assign gap_raw = ~plan_q;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_nxt           = s_r;
    start_mark      = 1'b0;
    // peer priority through two flops before use
    s_nxt.prio_meta = peer_priority_pin;
    s_nxt.prio_sync = s_r.prio_meta;
    // enable sequencing; turning on waits for a frame boundary
    case (s_r.mode)
      RCRT_OFF: begin
        if (rt_enable) begin
          s_nxt.mode = RCRT_ARMED;
        end
      end
      RCRT_ARMED: begin
        if (!rt_enable) begin
          s_nxt.mode = RCRT_OFF;
        end else if (l1_in.frame_tick) begin
          s_nxt.mode = RCRT_ON;
          start_mark = 1'b1;
        end
      end
      RCRT_ON: begin
        if (!rt_enable) begin
          s_nxt.mode = RCRT_OFF;
        end else begin
          start_mark = l1_in.frame_tick;
        end
      end
      default: begin
        s_nxt.mode = RCRT_OFF;
      end
    endcase
    // frame marker: fixed-width pulse from each frame tick
    if (start_mark) begin
      s_nxt.mark_cnt = MARK_LOAD;
    end else if (s_r.mark_cnt != '0) begin
      s_nxt.mark_cnt = s_r.mark_cnt - 1'b1;
    end
    if (s_nxt.mode != RCRT_ON) begin
      s_nxt.mark_cnt = '0;
    end
    s_nxt.marker    = s_nxt.mark_cnt != '0;
    // envelope pin only while coordination runs
    s_nxt.envelope  = (s_r.mode == RCRT_ON) && rt_enable && gap_raw;
    // lte keeps its slot; a high priority peer on top of it is flagged
    s_nxt.collision = (s_r.mode == RCRT_ON) && s_r.prio_sync && ul_tx_air;
  end

  // state register
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      s_r <= '{prio_meta: 1'b0, prio_sync: 1'b0, mode: RCRT_OFF,
               mark_cnt: '0, marker: PIN_IDLE, envelope: PIN_IDLE, collision: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign frame_marker_pin        = s_r.marker;
  assign uplink_gap_envelope_pin = s_r.envelope;
  assign l1_out.ul_tx_air        = ul_tx_air;
  assign l1_out.peer_hipri       = s_r.prio_sync;
  assign l1_out.peer_collision   = s_r.collision;
  assign l1_out.queue_overflow   = overflow;
  assign l1_out.rt_active        = s_r.mode == RCRT_ON;

  // ****************************************
  // checks
  // ****************************************
  // cycles since the raw gap last fell (uplink plan rose); saturated until the first fall
  logic [STAMP_W-1:0] since_fall_r;
  logic [MARK_CNT_W-1:0] mark_len_r;
  logic               gap_raw_d_r;
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      since_fall_r <= '1;
      gap_raw_d_r  <= 1'b1;
      mark_len_r   <= '0;
    end else begin
      gap_raw_d_r  <= gap_raw;
      since_fall_r <= (gap_raw_d_r && !gap_raw) ? STAMP_W'(1) :
                      ((since_fall_r == '1) ? since_fall_r : since_fall_r + 1'b1);
      // a restarted pulse is measured from its own start
      mark_len_r   <= start_mark ? '0 : (s_r.marker ? mark_len_r + 1'b1 : '0);
    end
  end

  property p_prio_sync;
    @(posedge core_clk) disable iff (!rst_sync_b)
    $past(rst_sync_b, 3) |-> l1_out.peer_hipri == $past(peer_priority_pin, 2);
  endproperty
  a_prio_sync: assert property (p_prio_sync) else $error("priority sync latency wrong");

  property p_mark_start;
    @(posedge core_clk) disable iff (!rst_sync_b)
    (s_r.mode == RCRT_ON && rt_enable && l1_in.frame_tick) |=> frame_marker_pin [*8];
  endproperty
  a_mark_start: assert property (p_mark_start) else $error("frame marker not raised");

  property p_mark_width;
    @(posedge core_clk) disable iff (!rst_sync_b)
    ($fell(frame_marker_pin) && s_r.mode == RCRT_ON) |-> mark_len_r == MARK_LOAD;
  endproperty
  a_mark_width: assert property (p_mark_width) else $error("frame marker width wrong");

  property p_gap_lead;
    @(posedge core_clk) disable iff (!rst_sync_b)
    (since_fall_r == STAMP_W'(LEAD_CYC) && !overflow) |-> $rose(ul_tx_air);
  endproperty
  a_gap_lead: assert property (p_gap_lead) else $error("envelope lead time wrong");

  property p_collision;
    @(posedge core_clk) disable iff (!rst_sync_b)
    (s_r.mode == RCRT_ON && s_r.prio_sync && ul_tx_air) |=> l1_out.peer_collision;
  endproperty
  a_collision: assert property (p_collision) else $error("collision not flagged");

  property p_stay_off;
    @(posedge core_clk) disable iff (!rst_sync_b)
    (!rt_enable && s_r.mode != RCRT_ON) |=> !l1_out.rt_active;
  endproperty
  a_stay_off: assert property (p_stay_off) else $error("active without enable");

  property p_idle_pins;
    @(posedge core_clk) disable iff (!rst_sync_b)
    (s_r.mode == RCRT_OFF) |=> (!frame_marker_pin && !uplink_gap_envelope_pin);
  endproperty
  a_idle_pins: assert property (p_idle_pins) else $error("pins driven while disabled");

  property p_env_follow;
    @(posedge core_clk) disable iff (!rst_sync_b)
    (s_r.mode == RCRT_ON && rt_enable) |=> uplink_gap_envelope_pin == !$past(plan_q);
  endproperty
  a_env_follow: assert property (p_env_follow) else $error("envelope not gap level");

endmodule : rcrt_top

// ==== bench/rcrt_peer_model.sv ====
// behavioural connectivity-side model driving the priority pin
`timescale 1ns/1ps
module rcrt_peer_model (
  // clock
  input  wire logic core_clk,
  // commands from the bench
  input  wire logic want_hi,
  input  wire logic overlap_ok,
  // coexistence pins
  input  wire logic uplink_gap_envelope_pin,
  input  wire logic frame_marker_pin,
  output logic      peer_priority_pin,
  output int        bt_frames
);
  logic marker_d = 1'b0;
  // bluetooth schedule follows the frame marker: count its rising edges
  initial bt_frames = 0;
  always @(negedge core_clk) begin
    marker_d <= frame_marker_pin;
    if (frame_marker_pin && !marker_d) bt_frames <= bt_frames + 1;
  end
  // high priority only inside an uplink gap, unless overlap is commanded
  initial peer_priority_pin = 1'b0;
  always @(negedge core_clk) begin
    peer_priority_pin <= want_hi & (uplink_gap_envelope_pin | overlap_ok);
  end
endmodule : rcrt_peer_model

// ==== bench/tb.sv ====
// scoreboard testbench for the real-time coexistence signalling block
`timescale 1ns/1ps
module tb;
  import rcrt_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  localparam int LEAD = 64;
  localparam int M = 6, E = 5, A = 4, H = 3, C = 2, R = 1;
  typedef struct {int c; logic [6:0] v;} rcrt_note_type;
  logic            core_clk, rst_b, rt_enable, want_hi, overlap_ok;
  logic            peer_pin, marker, envelope;
  rcrt_l1_in_type  l1_in;
  rcrt_l1_out_type l1_out;
  rcrt_note_type   q[$];
  logic [6:0]      exp_v, last_v, seen_v;
  int              cyc = 0;
  int              bt_frames;
  int              failures = 0;
  int              tests_run = 0;
  bit              mon_on = 0;

  rcrt_top #(.LEAD_CYC(LEAD)) rcrt_top_inst (.core_clk(core_clk), .rst_b(rst_b),
    .rt_enable(rt_enable), .l1_in(l1_in), .l1_out(l1_out), .frame_marker_pin(marker),
    .uplink_gap_envelope_pin(envelope), .peer_priority_pin(peer_pin));
  rcrt_peer_model rcrt_peer_model_inst (.core_clk(core_clk), .want_hi(want_hi),
    .overlap_ok(overlap_ok), .uplink_gap_envelope_pin(envelope),
    .frame_marker_pin(marker), .peer_priority_pin(peer_pin), .bt_frames(bt_frames));

  // clock and cycle count
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) cyc <= cyc + 1;

  // ****************************************
  // tasks
  // ****************************************
  task automatic results();
    if (failures == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  task automatic check(logic [31:0] seen, logic [31:0] want, string what);
    tests_run++;
    if (seen !== want) begin
      failures++;
      $display("mismatch at %0t: %s seen %0h expected %0h", $time, what, seen, want);
    end
  endtask : check

  // record an expected output change at a cycle
  task automatic note(int c, int b, logic v, bit push = 1);
    exp_v[b] = v;
    if (push) q.push_back('{c, exp_v});
  endtask : note

  task automatic wait_cyc(int n);
    repeat (n) @(negedge core_clk);
  endtask : wait_cyc

  // bounded wait until every expected change was seen
  task automatic drain();
    int i;
    for (i = 0; i < 400 && q.size() != 0; i++) @(negedge core_clk);
    if (q.size() != 0) begin
      failures++;
      results();
    end
  endtask : drain

  task automatic pulse_tick();
    l1_in.frame_tick <= 1'b1;
    @(negedge core_clk);
    l1_in.frame_tick <= 1'b0;
  endtask : pulse_tick

  // toggle the uplink plan n times back to back
  task automatic burst(int n, bit chk = 1);
    int   c0, i;
    logic p;
    c0 = cyc;
    p = l1_in.ul_tx_plan;
    if (chk) begin
      for (i = 0; i < n; i++) if (exp_v[R] === 1'b1) note(c0 + i + 2, E, p ^ i[0]);
      for (i = 0; i < n; i++) note(c0 + i + LEAD + 1, A, ~p ^ i[0]);
    end
    for (i = 0; i < n; i++) begin
      l1_in.ul_tx_plan <= ~l1_in.ul_tx_plan;
      @(negedge core_clk);
    end
  endtask : burst

  // peer raises priority for w cycles
  task automatic peer_pulse(int w);
    bit col;
    col = exp_v[R] & exp_v[A];
    note(cyc + 3, H, 1'b1);
    if (col) note(cyc + 4, C, 1'b1);
    note(cyc + w + 3, H, 1'b0);
    if (col) note(cyc + w + 4, C, 1'b0);
    want_hi <= 1'b1;
    wait_cyc(w);
    want_hi <= 1'b0;
  endtask : peer_pulse

  // ****************************************
  // output monitor
  // ****************************************
  always @(negedge core_clk) begin
    seen_v = {marker, envelope, l1_out.ul_tx_air, l1_out.peer_hipri,
              l1_out.peer_collision, l1_out.rt_active, l1_out.queue_overflow};
    if (mon_on && seen_v !== last_v) begin
      if (q.size() == 0) check(seen_v, last_v, "unexpected change");
      else begin
        check(seen_v, q[0].v, "outputs");
        check(cyc, q[0].c, "change cycle");
        void'(q.pop_front());
      end
    end
    last_v = seen_v;
  end

  // watchdog
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    results();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    int d, i;
    rst_b = 1'b0;
    rt_enable = 1'b0;
    want_hi = 1'b0;
    overlap_ok = 1'b0;
    l1_in = '0;
    exp_v = '0;
    last_v = '0;
    void'($urandom(39));
    wait_cyc(3);
    rst_b <= 1'b1;
    wait_cyc(3);
    mon_on = 1;
    // idle: air follows the plan, pins stay low, ticks ignored
    burst(1);
    drain();
    pulse_tick();
    wait_cyc(60);
    // enable, first tick starts the marker, second restarts it
    rt_enable <= 1'b1;
    wait_cyc(2);
    note(cyc + 1, R, 1'b1, 0);
    note(cyc + 1, M, 1'b1);
    pulse_tick();
    d = $urandom_range(30, 5);
    wait_cyc(d);
    note(cyc + 41, M, 1'b0);
    pulse_tick();
    drain();
    // plan bursts up to the queue limit
    for (i = 0; i < 6; i++) begin
      burst(i == 0 ? 8 : $urandom_range(7, 1));
      drain();
    end
    if (!l1_in.ul_tx_plan) begin
      burst(1);
      drain();
    end
    // polite peer stays low outside gaps
    want_hi <= 1'b1;
    wait_cyc(20);
    want_hi <= 1'b0;
    wait_cyc(4);
    // peer forced high while uplink is on air
    overlap_ok <= 1'b1;
    for (i = 0; i < 4; i++) begin
      peer_pulse($urandom_range(10, 2));
      drain();
    end
    overlap_ok <= 1'b0;
    burst(1);
    drain();
    peer_pulse(3);
    drain();
    // disable mid marker and mid gap
    note(cyc + 1, M, 1'b1);
    pulse_tick();
    wait_cyc(10);
    note(cyc + 1, R, 1'b0, 0);
    note(cyc + 1, E, 1'b0, 0);
    note(cyc + 1, M, 1'b0);
    rt_enable <= 1'b0;
    drain();
    // too many pending edges
    mon_on = 0;
    burst(10, 0);
    for (i = 0; i < 100 && l1_out.queue_overflow !== 1'b1; i++) @(negedge core_clk);
    check(l1_out.queue_overflow, 1'b1, "overflow");
    check(bt_frames, 2, "marker frames");
    results();
  end
endmodule : tb
